// >>> core/gss_regs.svh
/*
  Register offsets, field positions, reset values and codes of the servo gain set switcher.
  Assumes 32-bit APB data, with one aligned word per register.
*/
`ifndef GSS_REGS_SVH
`define GSS_REGS_SVH

// ==========================================================
// Register byte addresses
`define GSS_ADDR_CTRL   12'h000
`define GSS_ADDR_LEVEL  12'h004
`define GSS_ADDR_BAND   12'h008
`define GSS_ADDR_DELAY  12'h00c
`define GSS_ADDR_STATUS 12'h010

// ==========================================================
// Fields
`define GSS_CODE_MSB    3
`define GSS_CODE_LSB    0
`define GSS_MODE_MSB    5
`define GSS_MODE_LSB    4
`define GSS_LVL_MSB     15
`define GSS_DLY_MSB     13
`define GSS_ST_GAIN2    0
`define GSS_ST_INTEG2   1
`define GSS_ST_DLYRUN   2

// ==========================================================
// Reset values and delay write limit (delay in 0.1 ms steps)
`define GSS_CODE_RST    4'h0
`define GSS_MODE_RST    2'h0
`define GSS_LEVEL_RST   16'h0032
`define GSS_BAND_RST    16'h001e
`define GSS_DELAY_RST   14'h0032
`define GSS_DELAY_MAX   14'h2710

// ==========================================================
// Control modes
`define GSS_MODE_POS    2'h0
`define GSS_MODE_SPD    2'h1
`define GSS_MODE_TRQ    2'h2
`define GSS_MODE_FCL    2'h3

// ==========================================================
// Selection codes
`define GSS_SEL_RATE    4'h4
`define GSS_SEL_RATE_HL 4'h5
`define GSS_SEL_DEV     4'h6
`define GSS_SEL_CMD     4'h7
`define GSS_SEL_DONE    4'h8
`define GSS_SEL_SPEED   4'h9
`define GSS_SEL_CMD_SPD 4'ha

// ==========================================================
// Timing: one delay step and the clock period
`define GSS_DELAY_STEP_NS 100000
`define GSS_CLK_PERIOD_NS 4

`endif

// >>> core/gss_pkg.sv
/*
  Types that are shared by the servo gain set switcher.
  Assumes nothing beyond the compile order.
*/
package gss_pkg;

  // ==========================================================
  // Gain selector states
  typedef enum logic [1:0] {
    GSS_GAIN1,
    GSS_GAIN2,
    GSS_PARTIAL
  } gss_gain_st_t;

endpackage : gss_pkg

// >>> core/gss_switcher.sv
/*
  Servo gain set switcher: picks the first or second gain set from trigger signals
  of the servo loops, with level, hysteresis band and a switch-back delay.
  Assumes the loop inputs run on pclk, so they need no synchroniser, and that
  sample_tick is a one-cycle pulse once per control-loop sample.
*/
`include "gss_regs.svh"

module gss_switcher #(
  parameter int DW          = 32,
  parameter int TICK_CYCLES = `GSS_DELAY_STEP_NS / `GSS_CLK_PERIOD_NS
) (
  // Clock and reset
  input  wire logic          pclk,
  input  wire logic          presetn,
  // APB slave
  input  wire logic          psel,
  input  wire logic          penable,
  input  wire logic          pwrite,
  input  wire logic [11:0]   paddr,
  input  wire logic [31:0]   pwdata,
  output logic      [31:0]   prdata,
  output logic               pready,
  output logic               pslverr,
  // Servo loop and command source
  input  wire logic          sample_tick,
  input  wire logic [DW-1:0] spd_cmd_rate,
  input  wire logic [DW-1:0] pos_dev,
  input  wire logic [DW-1:0] pos_cmd,
  input  wire logic [DW-1:0] act_speed,
  input  wire logic          positioning_done,
  // Gain selection
  output logic               gain2_sel,
  output logic               integ2_sel
);

  // ==========================================================
  // State
  typedef struct packed {
    logic [3:0]           code;
    logic [1:0]           mode;
    logic [15:0]          level;
    logic [15:0]          band;
    logic [13:0]          delay;
    logic [31:0]          rdata;
    logic [15:0]          presc;
    logic [13:0]          cnt;
    logic                 rel;
    gss_pkg::gss_gain_st_t st;
    logic                 g2;
    logic                 i2;
  } gss_state_t;

  gss_state_t s_reg;
  gss_state_t s_next;

  logic [DW-1:0] rate_abs;
  logic [DW-1:0] dev_abs;
  logic [DW-1:0] spd_abs;
  logic [15:0]   eff_lvl;
  logic [DW-1:0] hi_w;
  logic [DW-1:0] lo_w;
  logic [DW-1:0] lvl_w;
  logic          code_ok;
  logic          set_c;
  logic          rel_c;
  logic          tick;
  logic          elapsed;
  logic          map_hit;
  logic [31:0]   rd_mux;

  function automatic logic [DW-1:0] abs_f(input logic [DW-1:0] v);
    abs_f = v[DW-1] ? (~v + {{(DW-1){1'b0}}, 1'b1}) : v;
  endfunction : abs_f

  // ==========================================================
  // Trigger arithmetic
  assign rate_abs = abs_f(spd_cmd_rate);
  assign dev_abs  = abs_f(pos_dev);
  assign spd_abs  = abs_f(act_speed);
  // Small level is raised to the band so level-band never underflows
  assign eff_lvl  = (s_reg.level < s_reg.band) ? s_reg.band : s_reg.level;
  assign lvl_w    = {{(DW-16){1'b0}}, eff_lvl};
  assign hi_w     = lvl_w + {{(DW-16){1'b0}}, s_reg.band};
  assign lo_w     = lvl_w - {{(DW-16){1'b0}}, s_reg.band};

  // Mode gating of the selection codes
  always_comb begin
    case (s_reg.code)
      `GSS_SEL_RATE, `GSS_SEL_RATE_HL:
        code_ok = (s_reg.mode != `GSS_MODE_SPD);
      `GSS_SEL_DEV, `GSS_SEL_CMD, `GSS_SEL_DONE, `GSS_SEL_SPEED, `GSS_SEL_CMD_SPD:
        code_ok = (s_reg.mode == `GSS_MODE_POS) || (s_reg.mode == `GSS_MODE_FCL);
      default:
        code_ok = 1'b0;
    endcase
  end

  // Switch and release conditions per code; the level comparisons use absolute values
  always_comb begin
    case (s_reg.code)
      `GSS_SEL_RATE, `GSS_SEL_RATE_HL: begin
        set_c = rate_abs > hi_w;
        rel_c = rate_abs < lo_w;
      end
      `GSS_SEL_DEV: begin
        set_c = dev_abs > hi_w;
        rel_c = dev_abs < lo_w;
      end
      `GSS_SEL_CMD, `GSS_SEL_CMD_SPD: begin
        set_c = (pos_cmd != '0);
        rel_c = (pos_cmd == '0);
      end
      `GSS_SEL_DONE: begin
        set_c = !positioning_done;
        rel_c = positioning_done;
      end
      `GSS_SEL_SPEED: begin
        set_c = spd_abs > hi_w;
        rel_c = spd_abs < lo_w;
      end
      default: begin
        set_c = 1'b0;
        rel_c = 1'b0;
      end
    endcase
  end

  assign tick    = (s_reg.presc == 16'(TICK_CYCLES - 1));
  assign elapsed = (s_reg.cnt >= s_reg.delay);

  // Register read decode
  always_comb begin
    map_hit = 1'b1;
    rd_mux  = 32'h0000_0000;
    case (paddr)
      `GSS_ADDR_CTRL: begin
        rd_mux[`GSS_CODE_MSB:`GSS_CODE_LSB] = s_reg.code;
        rd_mux[`GSS_MODE_MSB:`GSS_MODE_LSB] = s_reg.mode;
      end
      `GSS_ADDR_LEVEL:  rd_mux[`GSS_LVL_MSB:0] = s_reg.level;
      `GSS_ADDR_BAND:   rd_mux[`GSS_LVL_MSB:0] = s_reg.band;
      `GSS_ADDR_DELAY:  rd_mux[`GSS_DLY_MSB:0] = s_reg.delay;
      `GSS_ADDR_STATUS: begin
        rd_mux[`GSS_ST_GAIN2]  = s_reg.g2;
        rd_mux[`GSS_ST_INTEG2] = s_reg.i2;
        rd_mux[`GSS_ST_DLYRUN] = s_reg.rel && (s_reg.st == gss_pkg::GSS_GAIN2);
      end
      default: map_hit = 1'b0;
    endcase
  end

  // ==========================================================
  // Next state
  always_comb begin
    s_next = s_reg;
    // Register writes land at the access phase; delay clamps to its top
    if (psel && penable && pwrite) begin
      case (paddr)
        `GSS_ADDR_CTRL: begin
          s_next.code = pwdata[`GSS_CODE_MSB:`GSS_CODE_LSB];
          s_next.mode = pwdata[`GSS_MODE_MSB:`GSS_MODE_LSB];
        end
        `GSS_ADDR_LEVEL: s_next.level = pwdata[`GSS_LVL_MSB:0];
        `GSS_ADDR_BAND:  s_next.band  = pwdata[`GSS_LVL_MSB:0];
        `GSS_ADDR_DELAY:
          s_next.delay = (pwdata[`GSS_DLY_MSB:0] > `GSS_DELAY_MAX) ?
                         `GSS_DELAY_MAX : pwdata[`GSS_DLY_MSB:0];
        default: ;
      endcase
    end
    // Read data captured in the setup cycle
    if (psel && !penable)
      s_next.rdata = rd_mux;
    // 0.1 ms prescaler, free running
    s_next.presc = tick ? 16'h0000 : s_reg.presc + 16'h0001;
    // Delay count advances only while the sampled release holds
    if (!s_reg.rel)
      s_next.cnt = 14'h0000;
    else if (tick && (s_reg.cnt != `GSS_DELAY_MAX))
      s_next.cnt = s_reg.cnt + 14'h0001;
    // Gain selector: first gain forced at once on an invalid code, else evaluated once per sample
    if (!code_ok) begin
      s_next.st  = gss_pkg::GSS_GAIN1;
      s_next.cnt = 14'h0000;
      s_next.rel = 1'b0;
    end else if (sample_tick) begin
      s_next.rel = rel_c;
      case (s_reg.st)
        gss_pkg::GSS_GAIN1: begin
          s_next.cnt = 14'h0000;
          if (set_c)
            s_next.st = gss_pkg::GSS_GAIN2;
        end
        gss_pkg::GSS_GAIN2: begin
          if (!rel_c)
            s_next.cnt = 14'h0000;
          else if (s_reg.rel && elapsed) begin
            if (s_reg.code != `GSS_SEL_CMD_SPD)
              s_next.st = gss_pkg::GSS_GAIN1;
            else if (spd_abs < lo_w)
              s_next.st = gss_pkg::GSS_GAIN1;
            else if (spd_abs < lvl_w)
              s_next.st = gss_pkg::GSS_PARTIAL;
            // Otherwise full second gain stays applied
          end
        end
        gss_pkg::GSS_PARTIAL: begin
          if (!rel_c) begin
            s_next.st  = gss_pkg::GSS_GAIN2;
            s_next.cnt = 14'h0000;
          end else if (spd_abs < lo_w)
            s_next.st = gss_pkg::GSS_GAIN1;
        end
        default: s_next.st = gss_pkg::GSS_GAIN1;
      endcase
    end
    // Partial return keeps only the integral constant on the second set
    s_next.g2 = (s_next.st == gss_pkg::GSS_GAIN2);
    s_next.i2 = (s_next.st != gss_pkg::GSS_GAIN1);
  end

  // ==========================================================
  // Registers; reset selects the first gain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_reg       <= '0;
      s_reg.code  <= `GSS_CODE_RST;
      s_reg.mode  <= `GSS_MODE_RST;
      s_reg.level <= `GSS_LEVEL_RST;
      s_reg.band  <= `GSS_BAND_RST;
      s_reg.delay <= `GSS_DELAY_RST;
      s_reg.st    <= gss_pkg::GSS_GAIN1;
    end else begin
      s_reg <= s_next;
    end
  end

  // Zero-wait slave; unmapped addresses answer with an error
  assign pready     = 1'b1;
  assign pslverr    = psel && penable && !map_hit;
  assign prdata     = s_reg.rdata;
  assign gain2_sel  = s_reg.g2;
  assign integ2_sel = s_reg.i2;

  // ==========================================================
  // Checks
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  a_spd_mode_first: assert property (
    (s_reg.code inside {`GSS_SEL_RATE, `GSS_SEL_RATE_HL}) && s_reg.mode == `GSS_MODE_SPD
    |=> !gain2_sel && !integ2_sel)
    else $error("gain2 selected in speed mode");
  a_pos_mode_gate: assert property (
    (s_reg.code >= `GSS_SEL_DEV) && (s_reg.code <= `GSS_SEL_CMD_SPD)
    && (s_reg.mode inside {`GSS_MODE_SPD, `GSS_MODE_TRQ}) |=> !gain2_sel)
    else $error("gain2 selected outside position mode");
  a_rate_switch: assert property (
    code_ok && s_reg.code == `GSS_SEL_RATE && s_reg.st == gss_pkg::GSS_GAIN1
    && sample_tick && rate_abs > hi_w |=> gain2_sel)
    else $error("rate trigger missed");
  a_dev_switch: assert property (
    code_ok && s_reg.code == `GSS_SEL_DEV && s_reg.st == gss_pkg::GSS_GAIN1
    && sample_tick && dev_abs > hi_w |=> gain2_sel)
    else $error("deviation trigger missed");
  a_done_switch: assert property (
    code_ok && s_reg.code == `GSS_SEL_DONE && !s_reg.g2 && !s_reg.i2
    && sample_tick && !positioning_done |=> gain2_sel)
    else $error("positioning trigger missed");
  a_return_after_delay: assert property (
    $fell(integ2_sel) && $past(code_ok) |-> $past(s_reg.cnt) >= $past(s_reg.delay))
    else $error("early return to first gain");
  a_cnt_restart: assert property (
    code_ok && s_reg.st == gss_pkg::GSS_GAIN2 && sample_tick && !rel_c
    |=> s_reg.cnt == 14'h0000 && gain2_sel)
    else $error("delay count not restarted");
  a_partial_integral: assert property (
    $rose(integ2_sel) |-> gain2_sel)
    else $error("integral raised without second gain");
  a_level_floor: assert property (
    eff_lvl >= s_reg.band && eff_lvl >= s_reg.level && lo_w <= lvl_w)
    else $error("effective level below band");

endmodule : gss_switcher

// >>> verif/gss_loop_model.sv
/*
  Loop-side model: servo loops and motion command source seen by the switcher.
  Assumes the bench names wanted values; the loops take them at the start of a sample.
*/
module gss_loop_model #(
  parameter int SP = 8
) (
  // Clock and reset
  input  wire logic        pclk,
  input  wire logic        presetn,
  // Wanted loop values
  input  wire logic [31:0] want_cmd,
  input  wire logic [31:0] want_spd,
  // Toward the switcher
  output logic             sample_tick,
  output logic [31:0]      spd_cmd_rate,
  output logic [31:0]      pos_dev,
  output logic [31:0]      pos_cmd,
  output logic [31:0]      act_speed,
  output logic             positioning_done
);
  timeunit 1ns;
  timeprecision 1ps;
  int ph;
  // ==========================================================
  // Values change half a sample before the tick, never beside it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ph               <= 0;
      sample_tick      <= 1'b0;
      spd_cmd_rate     <= 32'h0;
      pos_dev          <= 32'h0;
      pos_cmd          <= 32'h0;
      act_speed        <= 32'h0;
      positioning_done <= 1'b1;
    end else begin
      ph          <= (ph == SP - 1) ? 0 : ph + 1;
      sample_tick <= (ph == SP / 2);
      if (ph == 0) begin
        spd_cmd_rate     <= want_spd;
        pos_dev          <= -want_spd;  // Opposite sign, so magnitude is what counts
        pos_cmd          <= want_cmd;
        act_speed        <= want_spd;
        positioning_done <= (want_cmd == 32'h0);
      end
    end
  end
endmodule : gss_loop_model

// >>> verif/tb_top.sv
/*
  Self-checking bench of the gain set switcher: APB register accesses and loop scenarios.
  Assumes a shortened 0.1 ms step (TICK_CYCLES) and the loop model beside the design.
*/
`include "gss_regs.svh"
module tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam int TK  = 4;   // Pclk cycles per delay step, shortened
  localparam int SP  = 8;   // Pclk cycles per loop sample
  localparam int DLY = 20;  // Delay steps used in most scenarios
  logic        pclk     = 1'b0;
  logic        presetn  = 1'b0;
  logic        psel     = 1'b0;
  logic        penable  = 1'b0;
  logic        pwrite   = 1'b0;
  logic [11:0] paddr    = 12'h0;
  logic [31:0] pwdata   = 32'h0;
  logic [31:0] want_cmd = 32'h0;
  logic [31:0] want_spd = 32'h0;
  logic [31:0] prdata, spd_cmd_rate, pos_dev, pos_cmd, act_speed;
  logic        pready, pslverr, sample_tick, positioning_done, gain2_sel, integ2_sel;
  logic [31:0] r;
  logic        e;
  int          fail_count = 0;
  int          compares   = 0;
  integer      seed       = 32'h5b0e;

  always #2 pclk = ~pclk;

  gss_switcher #(.TICK_CYCLES(TK)) uut (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .sample_tick(sample_tick), .spd_cmd_rate(spd_cmd_rate), .pos_dev(pos_dev),
    .pos_cmd(pos_cmd), .act_speed(act_speed), .positioning_done(positioning_done),
    .gain2_sel(gain2_sel), .integ2_sel(integ2_sel));

  gss_loop_model #(.SP(SP)) loops (
    .pclk(pclk), .presetn(presetn), .want_cmd(want_cmd), .want_spd(want_spd),
    .sample_tick(sample_tick), .spd_cmd_rate(spd_cmd_rate), .pos_dev(pos_dev),
    .pos_cmd(pos_cmd), .act_speed(act_speed), .positioning_done(positioning_done));

  // ==========================================================
  // Comparison, verdict and bus tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
    compares++;
    if (seen !== exp) begin
      fail_count++;
      $display("mismatch at %0t: %s seen %h expected %h", $time, what, seen, exp);
    end
  endtask : check

  task automatic print_verdict();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask : print_verdict

  // Request held until pready is sampled high; data taken at that edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel   <= 1'b1;
    pwrite <= w;
    paddr  <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    r = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic cyc(input int n);
    repeat (n) @(posedge pclk);
  endtask : cyc

  task automatic drive(input logic [31:0] c, input logic [31:0] s);
    @(posedge pclk);
    want_cmd <= c;
    want_spd <= s;
  endtask : drive

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] sgn(input int m);
    return ($random(seed) & 1) ? -m : m;
  endfunction : sgn

  function automatic int mag(input int lo, input int span);
    return lo + int'($unsigned($random(seed)) % span);
  endfunction : mag

  // Codes 4/5 work outside speed mode; 6..10 in position or full closed loop only
  function automatic logic [1:0] expect_gain(input int c, input int m);
    if (c <= 5) return (m != 1) ? 2'b11 : 2'b00;
    return (m == 0 || m == 3) ? 2'b11 : 2'b00;
  endfunction : expect_gain

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, `GSS_ADDR_LEVEL, 32'h0);
    check(r, `GSS_LEVEL_RST, "level reset");
    apb(1'b0, `GSS_ADDR_DELAY, 32'h0);
    check(r, `GSS_DELAY_RST, "delay reset");
    apb(1'b0, 12'h0f0, 32'h0);
    check(e, 1'b1, "unmapped");
    check({gain2_sel, integ2_sel}, 2'b00, "reset gain");
    apb(1'b1, `GSS_ADDR_DELAY, 32'h3fff);
    apb(1'b0, `GSS_ADDR_DELAY, 32'h0);
    check(r, `GSS_DELAY_MAX, "delay clamp");
    apb(1'b1, `GSS_ADDR_DELAY, DLY);
    // Every code in every mode: switch, hold through delay, return
    for (int m = 0; m < 4; m++) begin
      for (int c = 4; c <= 10; c++) begin
        apb(1'b1, `GSS_ADDR_CTRL, 32'(m * 16 + c));
        if (c == 7 || c == 8 || c == 10) drive(sgn(mag(1, 999)), 32'h0);
        else drive(32'h0, sgn(mag(81, 900)));
        cyc(3 * SP);
        check({gain2_sel, integ2_sel}, expect_gain(c, m), "switch");
        drive(32'h0, sgn(mag(0, 20)));
        cyc((DLY - 2) * TK);
        check({gain2_sel, integ2_sel}, expect_gain(c, m), "hold");
        cyc(2 * TK + 3 * SP);
        check({gain2_sel, integ2_sel}, 2'b00, "return");
      end
    end
    // Interrupted release restarts the count; status shows both selects
    apb(1'b1, `GSS_ADDR_CTRL, 32'h6);
    drive(32'h0, 32'd500);
    cyc(3 * SP);
    apb(1'b0, `GSS_ADDR_STATUS, 32'h0);
    check(r, 32'h3, "status");
    drive(32'h0, 32'h0);
    cyc((DLY / 2) * TK);
    drive(32'h0, 32'd500);
    cyc(2 * SP);
    drive(32'h0, 32'h0);
    cyc((DLY - 2) * TK);
    check({gain2_sel, integ2_sel}, 2'b11, "restart");
    cyc(2 * TK + 3 * SP);
    check({gain2_sel, integ2_sel}, 2'b00, "after restart");
    // Code 10 partial return in two stages
    apb(1'b1, `GSS_ADDR_CTRL, 32'ha);
    drive(32'd3, 32'h0);
    cyc(3 * SP);
    drive(32'h0, sgn(mag(20, 30)));
    cyc((DLY - 2) * TK);
    check({gain2_sel, integ2_sel}, 2'b11, "full second");
    cyc(2 * TK + 3 * SP);
    check({gain2_sel, integ2_sel}, 2'b01, "partial");
    drive(32'h0, sgn(mag(0, 20)));
    cyc(3 * SP);
    check({gain2_sel, integ2_sel}, 2'b00, "integral back");
    // Level below band is raised to the band: 55 stays, 61 switches
    apb(1'b1, `GSS_ADDR_LEVEL, 32'd10);
    apb(1'b1, `GSS_ADDR_CTRL, 32'h39);
    drive(32'h0, sgn(55));
    cyc(3 * SP);
    check({gain2_sel, integ2_sel}, 2'b00, "raised level");
    drive(32'h0, sgn(61));
    cyc(3 * SP);
    check({gain2_sel, integ2_sel}, 2'b11, "above raised");
    // Leaving the valid mode forces the first gain at once
    apb(1'b1, `GSS_ADDR_CTRL, 32'h29);
    cyc(2);
    check({gain2_sel, integ2_sel}, 2'b00, "mode refused");
    // Zero delay returns on the next release samples
    apb(1'b1, `GSS_ADDR_DELAY, 32'h0);
    apb(1'b1, `GSS_ADDR_CTRL, 32'h7);
    drive(32'd1, 32'h0);
    cyc(3 * SP);
    drive(32'h0, 32'h0);
    cyc(4 * SP);
    check({gain2_sel, integ2_sel}, 2'b00, "zero delay");
    print_verdict();
  end

  // Watchdog well beyond the expected run of about 4200 cycles
  initial begin
    #200000;
    fail_count++;
    print_verdict();
  end
endmodule : tb_top
